/* File: fixed_reference_control.v */
// Control and status register for the fixed reference and temperature indicator.
// Assumes single-clock register port; analog settled signals come from pins.
//
// What this block does
// - Bit 7 turns the reference on/off
// - Ready set only after circuits report stable
// - Ready read-only, zero when off or unsettled
// - Wide-supply variant: ready always reads one
// - Bits 3-2 select comparator buffer gain/off
// - Bits 1-0 select ADC buffer gain/off
// - Bit 5 enables temperature indicator
// - Bit 4 selects high/low temperature range
// - Writable fields clear to zero on reset
`timescale 1ns/1ps
`include "fixed_reference_regs.vh"

module fixed_reference_control
#(
  parameter WIDE_SUPPLY   = 0,               // 1 = ready always reads one
  parameter SETTLE_CYCLES = `SETTLE_CYCLES   // Fallback settle time in cycles
)
(
  clk,
  sys_rst,
  clk_en,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  ref_stable_in,
  amp_stable_in,
  reference_enable,
  temp_indicator_enable,
  temp_range_select,
  adc_ref_gain,
  comparator_ref_gain,
  adc_gain_sel,
  comparator_gain_sel,
  reference_ready_flag
);
  input  wire                clk;                    // System clock
  input  wire                sys_rst;                // Sync reset, high
  input  wire                clk_en;                 // Freeze all state when low
  input  wire [`ADDR_W-1:0]  reg_addr;               // Register address
  input  wire [`DATA_W-1:0]  reg_wdata;              // Write data
  input  wire                reg_wr;                 // Write strobe
  input  wire                reg_rd;                 // Read strobe
  output reg  [`DATA_W-1:0]  reg_rdata;              // Read data, one cycle later
  input  wire                ref_stable_in;          // Analog reference settled
  input  wire                amp_stable_in;          // Analog amplifiers settled
  output reg                 reference_enable;       // Reference power
  output reg                 temp_indicator_enable;  // Temp indicator power
  output reg                 temp_range_select;      // 1 = high range
  output reg  [1:0]          adc_ref_gain;           // Raw ADC gain field
  output reg  [1:0]          comparator_ref_gain;    // Raw comparator gain field
  output reg  [2:0]          adc_gain_sel;           // One-hot ADC gain
  output reg  [2:0]          comparator_gain_sel;    // One-hot comparator gain
  output reg                 reference_ready_flag;   // Reference ready

  // Pin synchronisers, three stages each
  reg  [2:0] ref_sync_q;
  reg  [2:0] amp_sync_q;
  reg        ref_stable_q;   // Filtered level
  reg        amp_stable_q;   // Filtered level

  // Settling state
  reg  [1:0]               state_q;
  reg  [1:0]               state_d;
  reg  [`SETTLE_CNT_W-1:0] cnt_q;
  reg  [`SETTLE_CNT_W-1:0] cnt_d;
  wire [`SETTLE_CNT_W-1:0] settle_last;

  // Decoder outputs
  wire [2:0] adc_dec;
  wire [2:0] cmp_dec;

  // Access decode
  wire wr_ctrl;
  wire ready_d;

  // Settling states
  localparam [1:0] ST_OFF    = `ST_OFF;     // Reference off
  localparam [1:0] ST_SETTLE = `ST_SETTLE;  // Waiting for stable reports
  localparam [1:0] ST_READY  = `ST_READY;   // Settled and usable

  assign settle_last = SETTLE_CYCLES[`SETTLE_CNT_W-1:0] - 1'b1;
  assign wr_ctrl     = reg_wr && (reg_addr == `REG_REF_CONTROL);

  // Gain field decoders
  gain_decode u_adc_dec
  (
    .sel    (adc_ref_gain),
    .onehot (adc_dec)
  );

  gain_decode u_cmp_dec
  (
    .sel    (comparator_ref_gain),
    .onehot (cmp_dec)
  );

  // Synchronise settled indications; a level counts when stages 2 and 3 agree
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ref_sync_q   <= 3'b000;
      amp_sync_q   <= 3'b000;
      ref_stable_q <= 1'b0;
      amp_stable_q <= 1'b0;
    end
    else if (clk_en)
    begin
      ref_sync_q <= {ref_sync_q[1:0], ref_stable_in};
      amp_sync_q <= {amp_sync_q[1:0], amp_stable_in};
      // Update only on agreement
      if (ref_sync_q[1] == ref_sync_q[2])
      begin
        ref_stable_q <= ref_sync_q[2];
      end
      if (amp_sync_q[1] == amp_sync_q[2])
      begin
        amp_stable_q <= amp_sync_q[2];
      end
    end
  end

  // Control fields; software writes, reset clears
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      reference_enable      <= 1'b0;
      temp_indicator_enable <= 1'b0;
      temp_range_select     <= 1'b0;
      adc_ref_gain          <= `GAIN_OFF;
      comparator_ref_gain   <= `GAIN_OFF;
    end
    else if (clk_en && wr_ctrl)
    begin
      // Bit 6 is read-only and ignored on write
      reference_enable      <= reg_wdata[`BIT_REF_ENABLE];
      temp_indicator_enable <= reg_wdata[`BIT_TEMP_ENABLE];
      temp_range_select     <= reg_wdata[`BIT_TEMP_RANGE];
      comparator_ref_gain   <= reg_wdata[`CMP_GAIN_HI:`CMP_GAIN_LO];
      adc_ref_gain          <= reg_wdata[`ADC_GAIN_HI:`ADC_GAIN_LO];
    end
  end

  // Settling sequence next state
  always @*
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_OFF:
      begin
        cnt_d = {`SETTLE_CNT_W{1'b0}};
        if (reference_enable)
        begin
          state_d = ST_SETTLE;
        end
      end
      ST_SETTLE:
      begin
        // Wait the minimum time, then for both analog reports
        if (!reference_enable)
        begin
          state_d = ST_OFF;
        end
        else if (cnt_q != settle_last)
        begin
          cnt_d = cnt_q + 1'b1;
        end
        else if (ref_stable_q && amp_stable_q)
        begin
          state_d = ST_READY;
        end
      end
      ST_READY:
      begin
        if (!reference_enable)
        begin
          state_d = ST_OFF;
        end
      end
      default:
      begin
        state_d = ST_OFF;
      end
    endcase
  end

  // Settling state registers
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_OFF;
      cnt_q   <= {`SETTLE_CNT_W{1'b0}};
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Ready: zero unless settled and still enabled, or tied high on wide supply
  assign ready_d = (WIDE_SUPPLY != 0) ? 1'b1 :
                   ((state_d == ST_READY) && reference_enable);

  // Registered analog controls and ready flag
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      adc_gain_sel         <= `ONEHOT_OFF;
      comparator_gain_sel  <= `ONEHOT_OFF;
      reference_ready_flag <= (WIDE_SUPPLY != 0);
    end
    else if (clk_en)
    begin
      adc_gain_sel         <= adc_dec;
      comparator_gain_sel  <= cmp_dec;
      reference_ready_flag <= ready_d;
    end
  end

  // Read port; unmapped addresses read zero
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= `READ_ZERO;
    end
    else if (clk_en)
    begin
      if (reg_rd && (reg_addr == `REG_REF_CONTROL))
      begin
        reg_rdata <= {reference_enable, reference_ready_flag, temp_indicator_enable,
                      temp_range_select, comparator_ref_gain, adc_ref_gain};
      end
      else if (reg_rd && (reg_addr == `REG_REF_STATUS))
      begin
        // Settling state and synchronised analog reports
        reg_rdata <= {4'h0, state_q, amp_stable_q, ref_stable_q};
      end
      else
      begin
        reg_rdata <= `READ_ZERO;
      end
    end
  end
endmodule // fixed_reference_control

/* File: fixed_reference_regs.vh */
// Constants for the fixed reference control register bank.
// Assumes a plain address/strobe register port with 8-bit data.
`ifndef FIXED_REFERENCE_REGS_VH
`define FIXED_REFERENCE_REGS_VH

// Register map
`define ADDR_W              4
`define DATA_W              8
`define REG_REF_CONTROL     4'h0
`define REG_REF_STATUS      4'h1

// Field positions in the control register
`define BIT_REF_ENABLE      7
`define BIT_READY_FLAG      6
`define BIT_TEMP_ENABLE     5
`define BIT_TEMP_RANGE      4
`define CMP_GAIN_HI         3
`define CMP_GAIN_LO         2
`define ADC_GAIN_HI         1
`define ADC_GAIN_LO         0

// Reset and fill values
`define CTRL_RESET          8'h00
`define READ_ZERO           8'h00
`define GAIN_OFF            2'b00
`define GAIN_X1             2'b01
`define GAIN_X2             2'b10
`define GAIN_X4             2'b11
`define ONEHOT_OFF          3'b000
`define ONEHOT_X1           3'b001
`define ONEHOT_X2           3'b010
`define ONEHOT_X4           3'b100

// Settling time, in ns, and derived cycle count at 125 MHz (8 ns)
`define SETTLE_NS           25000
`define CLK_PERIOD_NS       8
`define SETTLE_CYCLES       ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CNT_W        13

// Settling FSM states
`define ST_OFF              2'b00
`define ST_SETTLE           2'b01
`define ST_READY            2'b10

`endif

/* File: gain_decode.v */
// Decoder from a 2-bit buffer gain field to one-hot gain selects.
// Assumes the caller registers the outputs.
`timescale 1ns/1ps
`include "fixed_reference_regs.vh"

module gain_decode
(
  sel,
  onehot
);
  input  wire [1:0] sel;     // Gain field
  output reg  [2:0] onehot;  // {x4, x2, x1}, all zero = buffer off

  // Plain code to one-hot
  always @*
  begin
    case (sel)
      `GAIN_X4: onehot = `ONEHOT_X4;
      `GAIN_X2: onehot = `ONEHOT_X2;
      `GAIN_X1: onehot = `ONEHOT_X1;
      default:  onehot = `ONEHOT_OFF;
    endcase
  end
endmodule // gain_decode

/* File: fixed_reference_control_assertions.sv */
// Checker for the fixed reference control register bank.
// Assumes it is bound onto fixed_reference_control; one clock, sync reset.
`timescale 1ns/1ps
`include "fixed_reference_regs.vh"
module fixed_reference_control_chk #(
  parameter SETTLE_CYCLES = 4  // Minimum settle count
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       ref_stable_in,
  input wire logic       amp_stable_in,
  input wire logic       reference_enable,
  input wire logic       temp_indicator_enable,
  input wire logic       temp_range_select,
  input wire logic [1:0] adc_ref_gain,
  input wire logic [1:0] comparator_ref_gain,
  input wire logic [2:0] adc_gain_sel,
  input wire logic [2:0] comparator_gain_sel,
  input wire logic       reference_ready_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire ctl_wr = reg_wr && clk_en && reg_addr == `REG_REF_CONTROL;  // Control write
  logic [15:0] on_cnt_q;  // Cycles since enable seen high
  // Gain field to one-hot select
  function automatic logic [2:0] oh(input logic [1:0] g);
    return g == 2'h0 ? 3'h0 : 3'h1 << (g - 2'h1);
  endfunction
  // Enable age counter
  always_ff @(posedge clk)
    if (sys_rst || !reference_enable)
      on_cnt_q <= 16'h0000;
    else if (on_cnt_q != 16'hFFFF)
      on_cnt_q <= on_cnt_q + 16'h0001;
  chk_enable_write: assert property (ctl_wr |=> reference_enable == $past(reg_wdata[7]))
    else $error("enable bit not taken");
  chk_temp_fields: assert property (ctl_wr |=> {temp_indicator_enable, temp_range_select} == $past(reg_wdata[5:4]))
    else $error("temperature fields not taken");
  chk_adc_decode: assert property (clk_en |=> adc_gain_sel == oh($past(adc_ref_gain)))
    else $error("adc gain decode wrong");
  chk_cmp_decode: assert property (clk_en |=> comparator_gain_sel == oh($past(comparator_ref_gain)))
    else $error("comparator gain decode wrong");
  chk_ready_off: assert property (!reference_enable |=> !reference_ready_flag)
    else $error("ready while disabled");
  chk_ready_time: assert property ($rose(reference_ready_flag) |-> on_cnt_q >= SETTLE_CYCLES)
    else $error("ready before settle time");
  chk_ready_stable: assert property ($rose(reference_ready_flag) |-> $past(ref_stable_in, 2) && $past(amp_stable_in, 2))
    else $error("ready without stable reports");
  chk_read_data: assert property (reg_rd && clk_en && reg_addr == 4'h0 |=> reg_rdata == $past({reference_enable,
    reference_ready_flag, temp_indicator_enable, temp_range_select, comparator_ref_gain, adc_ref_gain}))
    else $error("control readback wrong");
  chk_reset_clear: assert property ($fell(sys_rst) |-> {reference_enable, temp_indicator_enable,
    temp_range_select, adc_ref_gain, comparator_ref_gain, adc_gain_sel, comparator_gain_sel} == 13'h0000)
    else $error("fields not cleared by reset");
endmodule  // fixed_reference_control_chk
bind fixed_reference_control fixed_reference_control_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_i (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_stable_in(ref_stable_in),
  .amp_stable_in(amp_stable_in), .reference_enable(reference_enable),
  .temp_indicator_enable(temp_indicator_enable), .temp_range_select(temp_range_select),
  .adc_ref_gain(adc_ref_gain), .comparator_ref_gain(comparator_ref_gain), .adc_gain_sel(adc_gain_sel),
  .comparator_gain_sel(comparator_gain_sel), .reference_ready_flag(reference_ready_flag));

/* File: fixed_reference_control_tb.sv */
// Self-checking bench for the fixed reference control register bank.
// Assumes a short settle count; read results checked against a queue.
`timescale 1ns/1ps
module fixed_reference_control_tb;
  logic       clk = 1'h0;      // 125 MHz clock
  logic       sys_rst = 1'h1;  // Sync reset
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] lf = 8'h5F;      // Random state
  logic       reg_wr = 1'h0;
  logic       reg_rd = 1'h0;
  logic       ref_ok = 1'h0;   // Reference settled report
  logic       amp_ok = 1'h0;   // Amplifier settled report
  logic       rd_d = 1'h0;     // Read taken last edge
  logic       en = 1'h1;       // Clock enable
  wire  [7:0] reg_rdata;
  logic [7:0] exp_q[$];        // Expected read data
  int         n_fail = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  fixed_reference_control #(.SETTLE_CYCLES(4)) fixed_reference_control_i (
    .clk(clk), .sys_rst(sys_rst), .clk_en(en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_stable_in(ref_ok),
    .amp_stable_in(amp_ok), .reference_enable(), .temp_indicator_enable(), .temp_range_select(),
    .adc_ref_gain(), .comparator_ref_gain(), .adc_gain_sel(), .comparator_gain_sel(),
    .reference_ready_flag());
  initial
    forever #4 clk = ~clk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      n_fail++;
      $display("[ERR] %0t read %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'h0;
  endtask
  task automatic reset(input int n);
    sys_rst <= 1'h1;
    repeat (n) @(posedge clk);
    sys_rst <= 1'h0;
  endtask
  // Result watcher and hang guard
  always @(posedge clk)
  begin
    if (rd_d)
      check(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
    cyc++;
    if (cyc > 2000)
    begin
      n_fail++;
      finish_test();
    end
  end
  // Main sequence
  initial
  begin
    reset(20);
    rd(4'h0, 8'h00);
    rd(4'h9, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      lf = lfsr(lf);
      wr(4'h0, {1'h0, lf[6:4], i[3:0]});
      rd(4'h0, {2'h0, lf[5:4], i[3:0]});
    end
    wr(4'h2, 8'hFF);
    rd(4'h0, {2'h0, lf[5:4], 4'hF});
    $display("test fields done");
    wr(4'h0, 8'h83);
    repeat (20) @(posedge clk);
    rd(4'h0, 8'h83);
    ref_ok <= 1'h1;
    amp_ok <= 1'h1;
    repeat (20) @(posedge clk);
    rd(4'h0, 8'hC3);
    rd(4'h1, 8'h0B);
    ref_ok <= 1'h0;
    rd(4'h0, 8'hC3);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00);
    ref_ok <= 1'h1;
    wr(4'h0, 8'h81);
    rd(4'h0, 8'h81);
    repeat (20) @(posedge clk);
    wr(4'h0, 8'hBF);
    rd(4'h0, 8'hFF);
    // A write while the clock enable is low must leave the fields alone
    en <= 1'h0;
    wr(4'h0, 8'h00);
    en <= 1'h1;
    rd(4'h0, 8'hFF);
    $display("test ready done");
    reset(1);
    rd(4'h0, 8'h00);
    $display("test rerun reset done");
    finish_test();
  end
endmodule  // fixed_reference_control_tb
